// File: logic/plee_pkg.sv
// package: constants and encodings of the postfix logic equation evaluator
package plee_pkg;
  localparam int unsigned LIST_DEPTH = 128;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned ARG_W = 8;
  localparam int unsigned OPC_W = 4;
  localparam int unsigned ENT_W = 12;
  localparam int unsigned OPC_LSB = 8;
  localparam int unsigned STK_W = 32;
  localparam int unsigned POP_W = 5;
  localparam int unsigned N_TMR = 32;
  localparam int unsigned N_VOUT = 64;
  localparam int unsigned N_OS = 32;
  localparam int unsigned N_LATCH = 32;
  localparam int unsigned N_EXT = 64;
  localparam int unsigned TMR_W = 16;
  localparam int unsigned IDX_W = 6;
  localparam logic [IDX_W-1:0] IDX_LIMIT = 6'h20;
  localparam logic [IDX_W-1:0] IDX_ONE = 6'h01;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 7'h7F;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 7'h01;
  localparam logic [TMR_W-1:0] TMR_ONE = 16'h0001;
  // operand source map: virtual outputs, timer outputs, external operands
  localparam logic [ARG_W-1:0] SRC_TMR_BASE = 8'h40;
  localparam logic [ARG_W-1:0] SRC_TMR_END = 8'h60;
  localparam logic [ARG_W-1:0] SRC_EXT_BASE = 8'h80;
  localparam logic [ARG_W-1:0] SRC_EXT_END = 8'hC0;
  // argument limits of timer, assignment and multi-input gates
  localparam logic [ARG_W-1:0] TMR_ARG_END = 8'h20;
  localparam logic [ARG_W-1:0] VO_ARG_END = 8'h40;
  localparam logic [ARG_W-1:0] GATE_MIN = 8'h02;
  localparam logic [ARG_W-1:0] GATE_MAX = 8'h10;
  localparam logic [POP_W-1:0] POP_NONE = 5'h00;
  localparam logic [POP_W-1:0] POP_ONE = 5'h01;
  localparam logic [POP_W-1:0] POP_TWO = 5'h02;
  localparam logic [STK_W-1:0] STK_ONE = 32'h00000001;
  typedef enum logic [OPC_W-1:0] {
    OPC_END, OPC_OPERAND, OPC_NOT, OPC_OR, OPC_AND, OPC_NOR, OPC_NAND, OPC_XOR,
    OPC_POS_OS, OPC_NEG_OS, OPC_DUAL_OS, OPC_LATCH, OPC_TIMER, OPC_ASSIGN
  } plee_opc_t;
  typedef enum logic [1:0] {EDIT_WRITE, EDIT_INSERT, EDIT_DELETE} plee_edit_t;
endpackage

// File: logic/plee_gate.sv
// gate evaluator: result and operand pop count of one list entry
`timescale 1ns/100ps
module plee_gate
  import plee_pkg::*;
(
  input wire logic [OPC_W-1:0] opc_i,
  input wire logic [ARG_W-1:0] arg_i,
  input wire logic [STK_W-1:0] stk_i,
  output logic res_o,
  output logic [POP_W-1:0] pop_o
);
  // select the top arg_i results of the stack
  wire logic [STK_W-1:0] mask_w = (STK_ONE << arg_i[POP_W-1:0]) - STK_ONE;
  wire logic any_w = |(stk_i & mask_w);
  wire logic all_w = &(stk_i | ~mask_w);
  wire logic multi_w = (opc_i == OPC_OR) || (opc_i == OPC_AND) || (opc_i == OPC_NOR)
                       || (opc_i == OPC_NAND);
  wire logic one_w = (opc_i == OPC_NOT) || (opc_i == OPC_POS_OS) || (opc_i == OPC_NEG_OS)
                     || (opc_i == OPC_DUAL_OS) || (opc_i == OPC_TIMER) || (opc_i == OPC_ASSIGN);
  wire logic two_w = (opc_i == OPC_XOR) || (opc_i == OPC_LATCH);

  // gate truth functions
  assign res_o = (opc_i == OPC_NOT) ? ~stk_i[0] :
                 (opc_i == OPC_OR) ? any_w :
                 (opc_i == OPC_AND) ? all_w :
                 (opc_i == OPC_NOR) ? ~any_w :
                 (opc_i == OPC_NAND) ? ~all_w :
                 (opc_i == OPC_XOR) ? (stk_i[0] ^ stk_i[1]) : 1'b0;

  // how many preceding results each entry consumes
  assign pop_o = multi_w ? arg_i[POP_W-1:0] :
                 one_w ? POP_ONE : two_w ? POP_TWO : POP_NONE;
endmodule

// File: logic/plee_timer.sv
// one timer operator: pickup and dropout counted in its own evaluations
`timescale 1ns/100ps
module plee_timer
  import plee_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic stb_i,
  input wire logic in_i,
  input wire logic [TMR_W-1:0] pickup_i,
  input wire logic [TMR_W-1:0] dropout_i,
  output logic out_o
);
  logic [TMR_W-1:0] cnt_q;
  logic out_q;
  wire logic [TMR_W-1:0] lim_w = in_i ? pickup_i : dropout_i;
  wire logic exp_w = cnt_q >= lim_w;

  // output follows the input once it has differed for one evaluation more than the set count
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || clr_i)
    begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end
    else if (stb_i)
    begin
      if (in_i == out_q)
        cnt_q <= '0;
      else if (exp_w)
      begin
        out_q <= in_i;
        cnt_q <= '0;
      end
      else
        cnt_q <= cnt_q + TMR_ONE;
    end
  end

  assign out_o = out_q;
endmodule

// File: logic/plee_core.sv
// postfix logic equation evaluator: list store, compiler and evaluation engine
//
// Overview of operation
// - NOT inverts the one result directly before it.
// - OR any true, AND all true, NOR all false, NAND any false.
// - OR, AND, NOR, NAND take 2..16 preceding results, consuming exactly that many.
// - XOR takes two preceding results, true when exactly one is true.
// - processing stops at the first END; later entries are ignored.
// - one-shots on rising, falling, and either edge of a single input.
// - one-shot output true for one pass only; at most 32 one-shots.
// - latch reset is previous result, set the one before; reset wins.
// - a set latch stays set after set drops, until reset.
// - up to 32 timers, started by previous result, own output and settings.
// - assignment drives one of 64 virtual outputs from previous result.
// - one result per operator; shared results go through a virtual output.
// - assignment ends the current equation; next entry starts a new one.
// - a timer or assignment used twice gives a syntax error.
// - entries evaluated in list order; later ones see earlier results.
// - latches come up cleared after reset.
// - any edit recompiles the list and clears every latch.
// - entries may be inserted or deleted at a chosen position.
`timescale 1ns/100ps
module plee_core
  import plee_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic pass_i,
  input wire logic edit_valid_i,
  input wire logic [1:0] edit_cmd_i,
  input wire logic [ADDR_W-1:0] edit_addr_i,
  input wire logic [ENT_W-1:0] edit_data_i,
  input wire logic [N_EXT-1:0] ext_op_i,
  input wire logic [N_TMR*TMR_W-1:0] tmr_pickup_i,
  input wire logic [N_TMR*TMR_W-1:0] tmr_dropout_i,
  output logic [N_VOUT-1:0] vout_o,
  output logic edit_ready_o,
  output logic busy_o,
  output logic pass_done_o,
  output logic syntax_err_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_COMPILE, ST_EVAL} plee_state_t;

  plee_state_t state_q;
  plee_state_t state_d;
  logic [ENT_W-1:0] mem_q [LIST_DEPTH];
  logic [ADDR_W-1:0] pc_q;
  logic [STK_W-1:0] stk_q;
  logic [IDX_W-1:0] os_idx_q;
  logic [IDX_W-1:0] lat_idx_q;
  logic [N_OS-1:0] os_prev_q;
  logic [N_LATCH-1:0] latch_q;
  logic [N_TMR-1:0] used_tmr_q;
  logic [N_VOUT-1:0] used_vo_q;
  logic err_pend_q;
  logic err_q;
  logic [N_VOUT-1:0] vout_q;
  logic ready_q;
  logic busy_q;
  logic done_q;
  logic [N_TMR-1:0] tmr_out_w;
  logic gate_res_w;
  logic [POP_W-1:0] pop_w;

  // ************************************************************
  // list store with write, insert and delete editing
  // ************************************************************
  wire logic edit_go_w = (state_q == ST_IDLE) && edit_valid_i;
  wire plee_edit_t edit_cmd_w = plee_edit_t'(edit_cmd_i);

  genvar k;
  generate
    for (k = 0; k < LIST_DEPTH; k++)
    begin : g_ent
      localparam int PRV = (k == 0) ? 0 : k - 1;
      localparam int NXT = (k == LIST_DEPTH - 1) ? k : k + 1;
      wire logic at_w = edit_addr_i == ADDR_W'(k);
      wire logic above_w = ADDR_W'(k) > edit_addr_i;
      wire logic [ENT_W-1:0] up_w = (k == LIST_DEPTH - 1) ? '0 : mem_q[NXT];
      // one entry: shifts up on insert, down on delete
      always_ff @(posedge mclk_i)
      begin
        if (rst_i)
          mem_q[k] <= '0;
        else if (edit_go_w)
        begin
          case (edit_cmd_w)
            EDIT_WRITE: if (at_w) mem_q[k] <= edit_data_i;
            EDIT_INSERT:
              if (at_w) mem_q[k] <= edit_data_i;
              else if (above_w) mem_q[k] <= mem_q[PRV];
            EDIT_DELETE: if (at_w || above_w) mem_q[k] <= up_w;
            default: mem_q[k] <= mem_q[k];
          endcase
        end
      end
    end
  endgenerate

  // ************************************************************
  // entry decode and operand selection
  // ************************************************************
  wire logic [ENT_W-1:0] ent_w = mem_q[pc_q];
  wire logic [OPC_W-1:0] opc_w = ent_w[ENT_W-1:OPC_LSB];
  wire logic [ARG_W-1:0] arg_w = ent_w[ARG_W-1:0];
  wire logic is_end_w = opc_w == OPC_END;
  wire logic run_w = (state_q != ST_IDLE) && !is_end_w;
  wire logic eval_w = (state_q == ST_EVAL) && !is_end_w;
  wire logic cmp_w = state_q == ST_COMPILE;
  wire logic is_os_w = (opc_w == OPC_POS_OS) || (opc_w == OPC_NEG_OS) || (opc_w == OPC_DUAL_OS);
  wire logic is_lat_w = opc_w == OPC_LATCH;
  wire logic is_tmr_w = opc_w == OPC_TIMER;
  wire logic is_asg_w = opc_w == OPC_ASSIGN;
  wire logic is_multi_w = (opc_w == OPC_OR) || (opc_w == OPC_AND) || (opc_w == OPC_NOR)
                          || (opc_w == OPC_NAND);

  // operand read sees values already assigned earlier in this pass
  wire logic src_w = (arg_w < SRC_TMR_BASE) ? vout_q[arg_w[5:0]] :
                     (arg_w < SRC_TMR_END) ? tmr_out_w[arg_w[4:0]] :
                     ((arg_w >= SRC_EXT_BASE) && (arg_w < SRC_EXT_END)) ?
                     ext_op_i[arg_w[5:0]] : 1'b0;

  plee_gate u_gate (
    .opc_i(opc_w),
    .arg_i(arg_w),
    .stk_i(stk_q),
    .res_o(gate_res_w),
    .pop_o(pop_w)
  );

  // one-shot and latch results against their held state
  wire logic cur_w = stk_q[0];
  wire logic os_prev_w = os_prev_q[os_idx_q[4:0]];
  wire logic lat_prev_w = latch_q[lat_idx_q[4:0]];
  wire logic os_res_w = (opc_w == OPC_POS_OS) ? (cur_w & ~os_prev_w) :
                        (opc_w == OPC_NEG_OS) ? (~cur_w & os_prev_w) :
                        (cur_w ^ os_prev_w);
  wire logic lat_res_w = ~stk_q[0] & (stk_q[1] | lat_prev_w);
  wire logic res_w = (opc_w == OPC_OPERAND) ? src_w : is_os_w ? os_res_w :
                     is_lat_w ? lat_res_w : is_tmr_w ? tmr_out_w[arg_w[4:0]] : gate_res_w;

  // pop the consumed results and push the single result
  wire logic [STK_W-1:0] stk_pop_w = stk_q >> pop_w;
  wire logic [STK_W-1:0] stk_next_w = is_asg_w ? '0 : {stk_pop_w[STK_W-2:0], res_w};

  // ************************************************************
  // compile checks
  // ************************************************************
  wire logic dup_tmr_w = is_tmr_w && ((arg_w >= TMR_ARG_END) || used_tmr_q[arg_w[4:0]]);
  wire logic dup_vo_w = is_asg_w && ((arg_w >= VO_ARG_END) || used_vo_q[arg_w[5:0]]);
  wire logic cnt_bad_w = is_multi_w && ((arg_w < GATE_MIN) || (arg_w > GATE_MAX));
  wire logic ovf_w = (is_os_w && (os_idx_q >= IDX_LIMIT)) || (is_lat_w && (lat_idx_q >= IDX_LIMIT));
  wire logic bad_w = cmp_w && !is_end_w && (dup_tmr_w || dup_vo_w || cnt_bad_w || ovf_w);
  wire logic last_w = is_end_w || (pc_q == ADDR_LAST);

  // ************************************************************
  // sequencer
  // ************************************************************
  // idle, compile after an edit, or evaluate one pass
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (edit_valid_i)
          state_d = ST_COMPILE;
        else if (pass_i && !err_q)
          state_d = ST_EVAL;
      ST_COMPILE: if (last_w) state_d = ST_IDLE;
      ST_EVAL: if (last_w) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // state and list pointer
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IDLE;
      pc_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      pc_q <= (state_d == ST_IDLE) ? '0 : (state_q == ST_IDLE) ? '0 : pc_q + ADDR_ONE;
    end
  end

  // result stack, empty at the start of every pass
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || (state_q != ST_EVAL))
      stk_q <= '0;
    else if (eval_w)
      stk_q <= stk_next_w;
  end

  // instance counters of one-shots and latches
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || (state_q == ST_IDLE))
    begin
      os_idx_q <= '0;
      lat_idx_q <= '0;
    end
    else if (run_w)
    begin
      if (is_os_w) os_idx_q <= os_idx_q + IDX_ONE;
      if (is_lat_w) lat_idx_q <= lat_idx_q + IDX_ONE;
    end
  end

  // held one-shot inputs and latch states
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || cmp_w)
    begin
      os_prev_q <= '0;
      latch_q <= '0;
    end
    else if (eval_w)
    begin
      if (is_os_w) os_prev_q[os_idx_q[4:0]] <= cur_w;
      if (is_lat_w) latch_q[lat_idx_q[4:0]] <= lat_res_w;
    end
  end

  // virtual outputs written in list order
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      vout_q <= '0;
    else if (eval_w && is_asg_w)
      vout_q[arg_w[5:0]] <= stk_q[0];
  end

  // duplicate tracking and syntax error
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || (state_q == ST_IDLE))
    begin
      used_tmr_q <= '0;
      used_vo_q <= '0;
      err_pend_q <= 1'b0;
    end
    else if (cmp_w && !is_end_w)
    begin
      if (is_tmr_w) used_tmr_q[arg_w[4:0]] <= 1'b1;
      if (is_asg_w) used_vo_q[arg_w[5:0]] <= 1'b1;
      if (bad_w) err_pend_q <= 1'b1;
    end
  end

  // status flags
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      err_q <= 1'b0;
      ready_q <= 1'b1;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      if (cmp_w && last_w) err_q <= err_pend_q || bad_w;
      ready_q <= state_d == ST_IDLE;
      busy_q <= state_d != ST_IDLE;
      done_q <= (state_q == ST_EVAL) && (state_d == ST_IDLE);
    end
  end

  // ************************************************************
  // timers
  // ************************************************************
  generate
    for (k = 0; k < N_TMR; k++)
    begin : g_tmr
      wire logic stb_w = eval_w && is_tmr_w && (arg_w[4:0] == 5'(k));
      plee_timer u_tmr (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .clr_i(cmp_w),
        .stb_i(stb_w),
        .in_i(stk_q[0]),
        .pickup_i(tmr_pickup_i[k*TMR_W +: TMR_W]),
        .dropout_i(tmr_dropout_i[k*TMR_W +: TMR_W]),
        .out_o(tmr_out_w[k])
      );
    end
  endgenerate

  assign vout_o = vout_q;
  assign edit_ready_o = ready_q;
  assign busy_o = busy_q;
  assign pass_done_o = done_q;
  assign syntax_err_o = err_q;

  // ************************************************************
  // assertions
  // ************************************************************
  wire logic top_w = stk_q[0];
  wire logic nxt_w = stk_q[1];
  wire logic [ARG_W-1:0] arg_h = arg_w;

  property p_not_inv;
    @(posedge mclk_i) disable iff (rst_i)
    eval_w && (opc_w == OPC_NOT) |=> stk_q[0] == !$past(top_w);
  endproperty
  a_not_inv: assert property (p_not_inv) else $error("not result wrong");

  property p_and_pop;
    @(posedge mclk_i) disable iff (rst_i)
    eval_w && (opc_w == OPC_AND) && (arg_w == GATE_MIN) && (stk_q[1:0] == 2'h3)
    |=> stk_q[0] && (stk_q[STK_W-1:1] == $past(stk_q[STK_W-1:2]));
  endproperty
  a_and_pop: assert property (p_and_pop) else $error("and(2) pop or result wrong");

  property p_nor_zero;
    @(posedge mclk_i) disable iff (rst_i)
    eval_w && (opc_w == OPC_NOR) && stk_q[0] |=> !stk_q[0];
  endproperty
  a_nor_zero: assert property (p_nor_zero) else $error("nor ignored true input");

  property p_xor;
    @(posedge mclk_i) disable iff (rst_i)
    eval_w && (opc_w == OPC_XOR) |=> stk_q[0] == ($past(top_w) ^ $past(nxt_w));
  endproperty
  a_xor: assert property (p_xor) else $error("xor result wrong");

  property p_end_stop;
    @(posedge mclk_i) disable iff (rst_i)
    (state_q == ST_EVAL) && is_end_w |=> (state_q == ST_IDLE) && pass_done_o && $stable(vout_q);
  endproperty
  a_end_stop: assert property (p_end_stop) else $error("pass did not stop at end");

  property p_pos_os;
    @(posedge mclk_i) disable iff (rst_i)
    eval_w && (opc_w == OPC_POS_OS) |=> stk_q[0] == ($past(top_w) && !$past(os_prev_w));
  endproperty
  a_pos_os: assert property (p_pos_os) else $error("rising one-shot wrong");

  property p_latch_rst;
    @(posedge mclk_i) disable iff (rst_i)
    eval_w && is_lat_w && stk_q[0] |=> !stk_q[0];
  endproperty
  a_latch_rst: assert property (p_latch_rst) else $error("latch reset did not win");

  property p_assign;
    @(posedge mclk_i) disable iff (rst_i)
    eval_w && is_asg_w |=> (vout_q[$past(arg_h[5:0])] == $past(top_w)) && (stk_q == '0);
  endproperty
  a_assign: assert property (p_assign) else $error("assignment wrong");

  property p_dup_err;
    @(posedge mclk_i) disable iff (rst_i)
    cmp_w && is_tmr_w && used_tmr_q[arg_w[4:0]] |-> ##[1:130] syntax_err_o;
  endproperty
  a_dup_err: assert property (p_dup_err) else $error("duplicate timer not flagged");

  property p_cmp_clear;
    @(posedge mclk_i) disable iff (rst_i)
    cmp_w |=> (latch_q == '0) && (os_prev_q == '0);
  endproperty
  a_cmp_clear: assert property (p_cmp_clear) else $error("latches not cleared");
endmodule

// File: test/plee_core_tb.sv
// self-checking testbench of the postfix logic equation evaluator
`timescale 1ns/100ps
module plee_core_tb;
  import plee_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pass_i = 1'b0;
  logic edit_valid_i = 1'b0;
  logic [1:0] edit_cmd_i = 2'h0;
  logic [ADDR_W-1:0] edit_addr_i = 7'h00;
  logic [ENT_W-1:0] edit_data_i = 12'h000;
  logic [N_EXT-1:0] ext_op_i = 64'h0;
  logic [N_TMR*TMR_W-1:0] tmr_pickup_i = {32{16'h0002}};
  logic [N_TMR*TMR_W-1:0] tmr_dropout_i = {32{16'h0001}};
  logic [N_VOUT-1:0] vout_o;
  logic edit_ready_o;
  logic busy_o;
  logic pass_done_o;
  logic syntax_err_o;
  int num_errors = 0;
  int n_compared = 0;
  int seed = 32'hDF0A48F6;
  logic [63:0] exp_q [$];
  logic [63:0] ev = 64'h0;
  logic [ENT_W-1:0] prog [$];
  int gsel [6][16];
  int gcnt [6];
  logic [3:0] gop [6];
  logic prev_q, latch_q, tout_q;
  int tcnt;

  plee_core uut (.mclk_i(mclk_i), .rst_i(rst_i), .pass_i(pass_i), .edit_valid_i(edit_valid_i),
    .edit_cmd_i(edit_cmd_i), .edit_addr_i(edit_addr_i), .edit_data_i(edit_data_i),
    .ext_op_i(ext_op_i), .tmr_pickup_i(tmr_pickup_i), .tmr_dropout_i(tmr_dropout_i),
    .vout_o(vout_o), .edit_ready_o(edit_ready_o), .busy_o(busy_o),
    .pass_done_o(pass_done_o), .syntax_err_o(syntax_err_o));

  // free-running clock
  always #5 mclk_i = ~mclk_i;

  // ***********************************
  // shared tasks
  // ***********************************
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic tick();
    @(posedge mclk_i);
    #1;
  endtask

  // bounded wait for the idle flag
  task automatic wait_idle();
    int n;
    n = 0;
    while (edit_ready_o !== 1'b1 && n < 400)
    begin
      tick();
      n++;
    end
    if (n >= 400)
      check("edit_ready_o", 64'h0, 64'h1);
  endtask

  task automatic edit(input logic [1:0] c, input int a, input logic [ENT_W-1:0] d);
    wait_idle();
    edit_cmd_i = c;
    edit_addr_i = 7'(a);
    edit_data_i = d;
    edit_valid_i = 1'b1;
    tick();
    edit_valid_i = 1'b0;
    tick();
    wait_idle();
  endtask

  // write the program queue from entry 0 and close it with an end entry
  task automatic load();
    foreach (prog[i])
      edit(EDIT_WRITE, i, prog[i]);
    edit(EDIT_WRITE, prog.size(), {OPC_END, 8'h00});
  endtask

  // note the expected outputs, then start one pass and wait for its end
  task automatic run_pass(input logic [63:0] exp);
    int n;
    wait_idle();
    exp_q.push_back(exp);
    pass_i = 1'b1;
    tick();
    pass_i = 1'b0;
    n = 0;
    while (pass_done_o !== 1'b1 && n < 400)
    begin
      tick();
      n++;
    end
    if (n >= 400)
      check("pass_done_o", 64'h0, 64'h1);
    tick();
  endtask

  // result of gate equation g for external levels e
  function automatic logic geval(input int g, input logic [63:0] e);
    int ones;
    ones = 0;
    for (int k = 0; k < gcnt[g]; k++)
      ones += e[gsel[g][k]];
    case (g)
      0: return ones == 0;
      1: return ones > 0;
      2: return ones == gcnt[g];
      3: return ones == 0;
      4: return ones < gcnt[g];
      default: return ones == 1;
    endcase
  endfunction

  // ***********************************
  // result monitor
  // ***********************************
  always @(negedge mclk_i) // sampled away from the edge that launches the pulse
  begin
    if (pass_done_o === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("unexpected_pass_done_o", 64'h1, 64'h0);
      else
        check("vout_o", vout_o, exp_q.pop_front());
    end
  end

  // watchdog on the whole run
  initial
  begin
    #900000;
    check("watchdog", 64'h1, 64'h0);
    give_verdict();
  end

  // ***********************************
  // main sequence
  // ***********************************
  initial
  begin
    repeat (3) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    check("reset_vout_o", vout_o, 64'h0);
    check("reset_flags", {edit_ready_o, busy_o, pass_done_o, syntax_err_o}, 64'h8);
    $display("test reset done");
    // every gate kind with boundary and random input counts
    gcnt = '{1, 2, 16, 2, 9, 2};
    gcnt[3] = 2 + ($unsigned($random(seed)) % 15);
    gcnt[4] = 2 + ($unsigned($random(seed)) % 15);
    gop = '{OPC_NOT, OPC_OR, OPC_AND, OPC_NOR, OPC_NAND, OPC_XOR};
    prog.delete();
    for (int g = 0; g < 6; g++)
    begin
      for (int k = 0; k < gcnt[g]; k++)
      begin
        gsel[g][k] = $unsigned($random(seed)) % 64;
        prog.push_back({OPC_OPERAND, 2'b10, 6'(gsel[g][k])});
      end
      prog.push_back({gop[g], 8'(gcnt[g])});
      prog.push_back({OPC_ASSIGN, 8'(g)});
    end
    prog.push_back({OPC_OPERAND, 8'h00});
    prog.push_back({OPC_NOT, 8'h00});
    prog.push_back({OPC_ASSIGN, 8'h06});
    load();
    edit(EDIT_WRITE, prog.size() + 1, {OPC_NOT, 8'h00});
    edit(EDIT_WRITE, prog.size() + 2, {OPC_ASSIGN, 8'h07});
    check("syntax_err_o", syntax_err_o, 64'h0);
    for (int p = 0; p < 12; p++)
    begin
      ext_op_i = {$random(seed), $random(seed)};
      for (int g = 0; g < 6; g++)
        ev[g] = geval(g, ext_op_i);
      ev[6] = !ev[0];
      run_pass(ev);
    end
    $display("test gates done");
    // one-shots, latch and timer over random passes, recompile halfway
    prog = '{{OPC_OPERAND, 8'h80}, {OPC_POS_OS, 8'h00}, {OPC_ASSIGN, 8'h0A},
      {OPC_OPERAND, 8'h80}, {OPC_NEG_OS, 8'h00}, {OPC_ASSIGN, 8'h0B},
      {OPC_OPERAND, 8'h80}, {OPC_DUAL_OS, 8'h00}, {OPC_ASSIGN, 8'h0C},
      {OPC_OPERAND, 8'h81}, {OPC_OPERAND, 8'h82}, {OPC_LATCH, 8'h00}, {OPC_ASSIGN, 8'h0D},
      {OPC_OPERAND, 8'h83}, {OPC_TIMER, 8'h00}, {OPC_ASSIGN, 8'h0E},
      {OPC_OPERAND, 8'h40}, {OPC_ASSIGN, 8'h0F}};
    load();
    prev_q = 1'b0;
    latch_q = 1'b0;
    tout_q = 1'b0;
    tcnt = 0;
    for (int p = 0; p < 40; p++)
    begin
      if (p == 20)
      begin
        edit(2'h3, 0, 12'h000);
        prev_q = 1'b0;
        latch_q = 1'b0;
        tout_q = 1'b0;
        tcnt = 0;
      end
      ext_op_i = {$random(seed), $random(seed)};
      ev[10] = ext_op_i[0] & !prev_q;
      ev[11] = !ext_op_i[0] & prev_q;
      ev[12] = ext_op_i[0] ^ prev_q;
      prev_q = ext_op_i[0];
      latch_q = !ext_op_i[2] & (latch_q | ext_op_i[1]);
      ev[13] = latch_q;
      ev[14] = tout_q;
      tcnt = (ext_op_i[3] != tout_q) ? tcnt + 1 : 0;
      if (tcnt == (ext_op_i[3] ? 3 : 2))
      begin
        tout_q = ext_op_i[3];
        tcnt = 0;
      end
      ev[15] = tout_q;
      run_pass(ev);
    end
    $display("test events done");
    // invalid lists raise the error flag and refuse passes
    for (int r = 0; r < 4; r++)
    begin
      case (r)
        0: prog = '{12'h180, 12'hD14, 12'h180, 12'hD14};
        1: prog = '{12'h180, 12'hC05, 12'h180, 12'hC05};
        2: prog = '{12'h180, 12'h180, 12'h301, 12'hD15};
        default: prog = '{12'h180, 12'h180, 12'h411, 12'hD15};
      endcase
      load();
      check("syntax_err_o", syntax_err_o, 64'h1);
      pass_i = 1'b1;
      tick();
      pass_i = 1'b0;
      repeat (6) tick();
      check("busy_o", busy_o, 64'h0);
    end
    $display("test syntax done");
    // insert then delete an inverter inside an equation
    prog = '{{OPC_OPERAND, 8'h80}, {OPC_ASSIGN, 8'h1E}};
    load();
    check("syntax_err_o", syntax_err_o, 64'h0);
    edit(EDIT_INSERT, 1, {OPC_NOT, 8'h00});
    ext_op_i = {$random(seed), $random(seed)};
    ev[30] = !ext_op_i[0];
    run_pass(ev);
    edit(EDIT_DELETE, 1, 12'h000);
    ev[30] = ext_op_i[0];
    run_pass(ev);
    $display("test edit done");
    // reset in mid-run empties list and outputs
    rst_i = 1'b1;
    repeat (3) tick();
    rst_i = 1'b0;
    ev = 64'h0;
    check("reset_vout_o", vout_o, 64'h0);
    run_pass(ev);
    $display("test second reset done");
    give_verdict();
  end
endmodule
